/* File: hdl/spiop_pkg.sv */
package spiop_pkg;

   // port width and bus widths
   localparam int unsigned PORT_W = 16;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_DIR_B    = 12'h2C6;
   localparam logic [11:0] IDX_PIN_B    = 12'h2C8;
   localparam logic [11:0] IDX_LAT_B    = 12'h2CB;
   localparam logic [11:0] IDX_DIR_C    = 12'h2CC;
   localparam logic [11:0] IDX_PIN_C    = 12'h2CE;
   localparam logic [11:0] IDX_LAT_C    = 12'h2D0;
   localparam logic [11:0] IDX_DIR_D    = 12'h2D2;
   localparam logic [11:0] IDX_PIN_D    = 12'h2D4;
   localparam logic [11:0] IDX_LAT_D    = 12'h2D6;
   localparam logic [11:0] IDX_ANALOG   = 12'h2D8;

   // byte addresses on the bus
   localparam logic [15:0] ADDR_DIR_B   = {2'b00, IDX_DIR_B, 2'b00};
   localparam logic [15:0] ADDR_PIN_B   = {2'b00, IDX_PIN_B, 2'b00};
   localparam logic [15:0] ADDR_LAT_B   = {2'b00, IDX_LAT_B, 2'b00};
   localparam logic [15:0] ADDR_DIR_C   = {2'b00, IDX_DIR_C, 2'b00};
   localparam logic [15:0] ADDR_PIN_C   = {2'b00, IDX_PIN_C, 2'b00};
   localparam logic [15:0] ADDR_LAT_C   = {2'b00, IDX_LAT_C, 2'b00};
   localparam logic [15:0] ADDR_DIR_D   = {2'b00, IDX_DIR_D, 2'b00};
   localparam logic [15:0] ADDR_PIN_D   = {2'b00, IDX_PIN_D, 2'b00};
   localparam logic [15:0] ADDR_LAT_D   = {2'b00, IDX_LAT_D, 2'b00};
   localparam logic [15:0] ADDR_ANALOG  = {2'b00, IDX_ANALOG, 2'b00};

   // implemented bits per port; direction resets to these (all inputs)
   localparam logic [15:0] IMPL_B       = 16'h03FF;
   localparam logic [15:0] IMPL_C       = 16'hE000;
   localparam logic [15:0] IMPL_D       = 16'h0001;
   localparam logic [15:0] LAT_RESET    = 16'h0000;
   localparam logic [15:0] PIN_RESET    = 16'h0000;
   localparam logic [15:0] ANALOG_RESET = 16'h0000;

   // pad drive towards the pins
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] oe;
   } spiop_pad_type;

   // peripheral request for a port's pins
   typedef struct packed {
      logic [15:0] active;
      logic [15:0] data;
   } spiop_periph_type;

endpackage : spiop_pkg

/* File: hdl/spiop_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - a peripheral actively driving a pin switches off the port driver but the pin stays readable.
// - a pin whose peripheral is not actively driving is driven from the port latch and direction.
// - a direction bit of one makes the pin an input; zero makes it an output driven by the latch.
// - after reset every implemented direction bit is set, so every pin is an input.
// - the latch register reads the stored latch and a write updates the latch.
// - the pin-level register reads sampled pin levels and a write to it updates the latch.
// - unimplemented bits are disabled and read as zero in latch, direction and pin-level.
// - per pin, two multiplexers pick peripheral or port for pad data and enable, peripheral first.
// - a pin shared only with an input peripheral is a plain port pin fully under port control.
// - pins set as analog inputs read as zero in the pin-level register.

// pair of pad multiplexers for one pin, peripheral first
module spiop_pad_mux
   import spiop_pkg::*;
#(
   parameter bit IMPLEMENTED = 1'b1
)(
   // peripheral side
   input  wire logic periph_active,
   input  wire logic periph_data,
   // port side
   input  wire logic port_oe,
   input  wire logic port_data,
   // pad side
   output logic      pad_oe,
   output logic      pad_data
);

   // data multiplexer: peripheral owns the pad data while active
   always_comb begin
      if (periph_active) begin
         pad_data = periph_data;
      end else begin
         pad_data = port_data;
      end
   end

   // enable multiplexer; an absent bit never switches its driver on
   always_comb begin
      if (periph_active) begin
         pad_oe = IMPLEMENTED;
      end else begin
         pad_oe = port_oe & IMPLEMENTED;
      end
   end

endmodule : spiop_pad_mux

// one port bank: latch, direction, sampled pins, pad multiplexers
module spiop_port
   import spiop_pkg::*;
#(
   parameter logic [15:0] IMPL_MASK = 16'hFFFF
)(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // register writes
   input  wire logic             dir_we,
   input  wire logic             lat_we,
   input  wire logic [15:0]      wdata,
   // analog pins of this port
   input  wire logic [15:0]      analog_pin_config,
   // pins and peripherals
   input  wire spiop_periph_type periph,
   input  wire logic [15:0]      pad_in,
   output spiop_pad_type         pad,
   // register contents
   output logic [15:0]           direction_reg,
   output logic [15:0]           output_latch_reg,
   output logic [15:0]           pin_level_reg
);

   logic      [15:0] pin_sample_reg;
   logic      [15:0] port_oe;
   logic      [15:0] read_mask;
   // per-pin multiplexer outputs, one driver for each bit
   wire logic [15:0] mux_oe;
   wire logic [15:0] mux_data;

   // direction register, inputs after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direction_reg <= IMPL_MASK;
      end else if (dir_we) begin
         direction_reg <= wdata & IMPL_MASK;
      end
   end

   // output latch, written by the latch or the pin-level address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_latch_reg <= LAT_RESET;
      end else if (lat_we) begin
         output_latch_reg <= wdata & IMPL_MASK;
      end
   end

   // single sample stage; inputs already synchronous to pclk;
   // a pad change needs one edge before a read setup to be seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sample_reg <= PIN_RESET;
      end else begin
         pin_sample_reg <= pad_in;
      end
   end

   // only implemented digital pins may show a level
   assign read_mask = IMPL_MASK & ~analog_pin_config;

   // read value masks out analog and unimplemented pins
   assign pin_level_reg = pin_sample_reg & read_mask;

   // port driver on only for an output direction
   assign port_oe = ~direction_reg & IMPL_MASK;

   // one multiplexer pair per pin, the peripheral outranks the port;
   // an input-only peripheral never raises active, so the port keeps the pin
   for (genvar i = 0; i < 16; i++) begin : g_pin
      spiop_pad_mux #(
         .IMPLEMENTED (IMPL_MASK[i])
      ) u_mux (
         .periph_active (periph.active[i]),
         .periph_data   (periph.data[i]),
         .port_oe       (port_oe[i]),
         .port_data     (output_latch_reg[i]),
         .pad_oe        (mux_oe[i]),
         .pad_data      (mux_data[i])
      );
   end

   // pad drive gathered back into the carrier struct
   assign pad = '{data: mux_data, oe: mux_oe};

endmodule : spiop_port

// register file over apb and three port banks
module spiop_top
   import spiop_pkg::*;
#(
   parameter logic [15:0] IMPL_MASK_B = IMPL_B,
   parameter logic [15:0] IMPL_MASK_C = IMPL_C,
   parameter logic [15:0] IMPL_MASK_D = IMPL_D
)(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [15:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // port b
   input  wire spiop_periph_type   periph_b,
   input  wire logic [15:0]        pad_in_b,
   output spiop_pad_type           pad_b,
   // port c
   input  wire spiop_periph_type   periph_c,
   input  wire logic [15:0]        pad_in_c,
   output spiop_pad_type           pad_c,
   // port d
   input  wire spiop_periph_type   periph_d,
   input  wire logic [15:0]        pad_in_d,
   output spiop_pad_type           pad_d,
   // analog selection to the converter
   output logic [15:0]             analog_pin_config
);

   logic        acc;
   logic        wr;
   logic        rd_setup;
   logic        hit;
   logic [15:0] rd_val;
   logic        we_dir_b;
   logic        we_lat_b;
   logic        we_dir_c;
   logic        we_lat_c;
   logic        we_dir_d;
   logic        we_lat_d;
   logic        we_analog;
   logic [15:0] dir_b;
   logic [15:0] lat_b;
   logic [15:0] pin_b;
   logic [15:0] dir_c;
   logic [15:0] lat_c;
   logic [15:0] pin_c;
   logic [15:0] dir_d;
   logic [15:0] lat_d;
   logic [15:0] pin_d;

   // zero wait states: every access ends at its first access cycle;
   // the price is that read data is captured at setup, one edge early
   assign pready   = 1'b1;
   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   // write strobes; a write to a pin-level address lands in the latch
   assign we_dir_b  = wr && (paddr == ADDR_DIR_B);
   assign we_lat_b  = wr && (paddr == ADDR_LAT_B || paddr == ADDR_PIN_B);
   assign we_dir_c  = wr && (paddr == ADDR_DIR_C);
   assign we_lat_c  = wr && (paddr == ADDR_LAT_C || paddr == ADDR_PIN_C);
   assign we_dir_d  = wr && (paddr == ADDR_DIR_D);
   assign we_lat_d  = wr && (paddr == ADDR_LAT_D || paddr == ADDR_PIN_D);
   assign we_analog = wr && (paddr == ADDR_ANALOG);

   // address decode and read multiplexer
   always_comb begin
      hit    = 1'b1;
      rd_val = 16'h0000;
      unique case (paddr)
         ADDR_DIR_B:  rd_val = dir_b;
         ADDR_PIN_B:  rd_val = pin_b;
         ADDR_LAT_B:  rd_val = lat_b;
         ADDR_DIR_C:  rd_val = dir_c;
         ADDR_PIN_C:  rd_val = pin_c;
         ADDR_LAT_C:  rd_val = lat_c;
         ADDR_DIR_D:  rd_val = dir_d;
         ADDR_PIN_D:  rd_val = pin_d;
         ADDR_LAT_D:  rd_val = lat_d;
         ADDR_ANALOG: rd_val = analog_pin_config;
         default:     hit    = 1'b0;
      endcase
   end

   // error answer for unmapped addresses, combinational with pready
   assign pslverr = acc & ~hit;

   // read data registered in the setup cycle so it stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {16'h0000, rd_val};
      end
   end

   // analog configuration, applies to port b pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_pin_config <= ANALOG_RESET;
      end else if (we_analog) begin
         analog_pin_config <= pwdata[15:0] & IMPL_MASK_B;
      end
   end

   // port b
   spiop_port #(.IMPL_MASK(IMPL_MASK_B)) u_port_b (
      .pclk              (pclk),
      .presetn           (presetn),
      .dir_we            (we_dir_b),
      .lat_we            (we_lat_b),
      .wdata             (pwdata[15:0]),
      .analog_pin_config (analog_pin_config),
      .periph            (periph_b),
      .pad_in            (pad_in_b),
      .pad               (pad_b),
      .direction_reg     (dir_b),
      .output_latch_reg  (lat_b),
      .pin_level_reg     (pin_b)
   );

   // port c
   spiop_port #(.IMPL_MASK(IMPL_MASK_C)) u_port_c (
      .pclk              (pclk),
      .presetn           (presetn),
      .dir_we            (we_dir_c),
      .lat_we            (we_lat_c),
      .wdata             (pwdata[15:0]),
      .analog_pin_config (16'h0000),
      .periph            (periph_c),
      .pad_in            (pad_in_c),
      .pad               (pad_c),
      .direction_reg     (dir_c),
      .output_latch_reg  (lat_c),
      .pin_level_reg     (pin_c)
   );

   // port d
   spiop_port #(.IMPL_MASK(IMPL_MASK_D)) u_port_d (
      .pclk              (pclk),
      .presetn           (presetn),
      .dir_we            (we_dir_d),
      .lat_we            (we_lat_d),
      .wdata             (pwdata[15:0]),
      .analog_pin_config (16'h0000),
      .periph            (periph_d),
      .pad_in            (pad_in_d),
      .pad               (pad_d),
      .direction_reg     (dir_d),
      .output_latch_reg  (lat_d),
      .pin_level_reg     (pin_d)
   );

endmodule : spiop_top

/* File: testbench/spiop_sva.sv */
`timescale 1ns/1ps
// bus and pad relations of the port block
module spiop_sva import spiop_pkg::*; (
   // bus
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [15:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pslverr,
   // port b pins
   input wire spiop_periph_type periph_b,
   input wire logic [15:0]      pad_in_b,
   input wire spiop_pad_type    pad_b,
   input wire logic [15:0]      analog_pin_config
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access and setup phases of a transfer
   sequence s_acc(a); psel && penable && pwrite && paddr == a; endsequence
   sequence s_set(a); psel && !penable && !pwrite && paddr == a; endsequence
   property p_oe; ((periph_b.active & IMPL_B) & ~pad_b.oe) == 16'h0000; endproperty
   property p_dat; ((pad_b.data ^ periph_b.data) & periph_b.active & IMPL_B) == 16'h0000; endproperty
   property p_unimpl; (pad_b.oe & ~IMPL_B) == 16'h0000; endproperty
   property p_rst; $rose(presetn) |-> pad_b.oe == (periph_b.active & IMPL_B); endproperty
   // pin sample is one edge old when the setup edge loads it
   property p_pin; s_set(ADDR_PIN_B) ##0 $past(presetn) |=>
      prdata[15:0] == ($past(pad_in_b, 2) & IMPL_B & ~analog_pin_config); endproperty
   property p_lat; s_acc(ADDR_PIN_B) ##1 s_set(ADDR_LAT_B) |=>
      prdata[15:0] == ($past(pwdata[15:0], 2) & IMPL_B); endproperty
   property p_err; psel && penable && paddr == 16'h0B1C |-> pslverr; endproperty
   property p_hi; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   a_oe: assert property (p_oe) else $error("periph oe lost");
   a_dat: assert property (p_dat) else $error("periph data lost");
   a_unimpl: assert property (p_unimpl) else $error("oe on absent bit");
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   a_pin: assert property (p_pin) else $error("pin read wrong");
   a_lat: assert property (p_lat) else $error("pin write missed latch");
   a_err: assert property (p_err) else $error("no slave error");
   a_hi: assert property (p_hi) else $error("upper half set");
endmodule : spiop_sva

bind spiop_top spiop_sva chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .periph_b(periph_b), .pad_in_b(pad_in_b),
   .pad_b(pad_b), .analog_pin_config(analog_pin_config)
);

/* File: testbench/spiop_board.sv */
`timescale 1ns/1ps
// board at one port: undriven pins follow an external level
module spiop_board import spiop_pkg::*; (
   // pad side
   input  wire spiop_pad_type pad,
   input  wire logic [15:0]   ext,
   output logic [15:0]        pad_in
);
   // no contention modelled: a driven pin shows the pad data
   assign pad_in = (pad.oe & pad.data) | (~pad.oe & ext);
endmodule : spiop_board

/* File: testbench/spiop_top_test.sv */
`timescale 1ns/1ps
// register and pad checks of the port block
module spiop_top_test import spiop_pkg::*; ;
   // bus, pins and counters
   logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic             pready, pslverr, err;
   logic [15:0]      paddr = 16'h0000, pad_in_b, pad_in_c, pad_in_d, ext_d = 16'hFFFF;
   logic [15:0]      analog_pin_config;
   logic [31:0]      pwdata = 32'h0, prdata, q;
   spiop_periph_type periph_b = '0, periph_c = '0, periph_d = '0;
   spiop_pad_type    pad_b, pad_c, pad_d;
   int               n_fail = 0, comparisons = 0;
   // 50 MHz clock
   always #10 pclk = ~pclk;
   // design, and boards that pull undriven pins high (port d follows ext_d)
   spiop_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .periph_b(periph_b), .pad_in_b(pad_in_b), .pad_b(pad_b),
      .periph_c(periph_c), .pad_in_c(pad_in_c), .pad_c(pad_c),
      .periph_d(periph_d), .pad_in_d(pad_in_d), .pad_d(pad_d),
      .analog_pin_config(analog_pin_config)
   );
   spiop_board brd_u (.pad(pad_b), .ext(16'hFFFF), .pad_in(pad_in_b));
   spiop_board brd_c_u (.pad(pad_c), .ext(16'hFFFF), .pad_in(pad_in_c));
   spiop_board brd_d_u (.pad(pad_d), .ext(ext_d), .pad_in(pad_in_d));
   // compare and count
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) n_fail++;
      if (got !== exp) $display("Error %s expected %h seen %h", n, exp, got);
   endtask : chk
   // apb transfer; no release here, so transfers can follow back to back
   task automatic xfer(input logic [15:0] a, input logic [31:0] d, input logic w);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
   endtask : xfer
   // bus idle for one cycle
   task automatic idle;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : idle
   // counts and verdict
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // hang guard, far beyond the roughly 70 cycles the tests need
   initial #40_000 begin
      n_fail++;
      end_sim;
   end
   // test sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(ADDR_DIR_B, 32'h0, 1'b0);
      chk("dir_b", q, 32'h03FF);
      xfer(ADDR_DIR_C, 32'h0, 1'b0);
      chk("dir_c", q, 32'hE000);
      xfer(ADDR_DIR_D, 32'h0, 1'b0);
      chk("dir_d", q, 32'h0001);
      xfer(ADDR_PIN_B, 32'h0, 1'b0);
      chk("pin_b", q, 32'h03FF);
      xfer(ADDR_LAT_C, 32'hFFFF, 1'b1);
      xfer(ADDR_LAT_C, 32'h0, 1'b0);
      chk("lat_c", q, 32'hE000);
      $display("reset done");
      xfer(ADDR_DIR_B, 32'h0, 1'b1);
      xfer(ADDR_PIN_B, 32'hAAAA, 1'b1);
      xfer(ADDR_LAT_B, 32'h0, 1'b0);
      chk("lat_b", q, 32'h02AA);
      idle;
      xfer(ADDR_PIN_B, 32'h0, 1'b0);
      chk("pin_b", q, 32'h02AA);
      $display("drive done");
      periph_b <= '{active: 16'h80F0, data: 16'h0050};
      repeat (2) idle;
      chk("oe_b", {16'h0, pad_b.oe}, 32'h03FF);
      chk("data_b", {16'h0, pad_b.data}, 32'h025A);
      xfer(ADDR_PIN_B, 32'h0, 1'b0);
      chk("pin_b", q, 32'h025A);
      xfer(ADDR_DIR_B, 32'h03FF, 1'b1);
      idle;
      chk("oe_b", {16'h0, pad_b.oe}, 32'h00F0);
      $display("periph done");
      periph_b <= '0;
      xfer(ADDR_ANALOG, 32'h000F, 1'b1);
      idle;
      xfer(ADDR_PIN_B, 32'h0, 1'b0);
      chk("pin_b", q, 32'h03F0);
      xfer(ADDR_ANALOG, 32'h0, 1'b0);
      chk("analog", q, 32'h000F);
      chk("analog_out", {16'h0, analog_pin_config}, 32'h000F);
      $display("analog done");
      xfer(ADDR_DIR_C, 32'h0, 1'b1);
      xfer(ADDR_PIN_C, 32'h5FFF, 1'b1);
      xfer(ADDR_LAT_C, 32'h0, 1'b0);
      chk("lat_c", q, 32'h4000);
      chk("oe_c", {16'h0, pad_c.oe}, 32'hE000);
      chk("data_c", {16'h0, pad_c.data}, 32'h4000);
      idle;
      xfer(ADDR_PIN_C, 32'h0, 1'b0);
      chk("pin_c", q, 32'h4000);
      xfer(ADDR_PIN_D, 32'h0, 1'b0);
      chk("pin_d", q, 32'h0001);
      ext_d <= 16'h0000;
      idle;
      xfer(ADDR_PIN_D, 32'h0, 1'b0);
      chk("pin_d", q, 32'h0000);
      periph_d <= '{active: 16'hFFFF, data: 16'h0000};
      xfer(ADDR_DIR_D, 32'hFFFE, 1'b1);
      xfer(ADDR_LAT_D, 32'hFFFF, 1'b1);
      idle;
      chk("oe_d", {16'h0, pad_d.oe}, 32'h0001);
      chk("data_d", {16'h0, pad_d.data}, 32'h0000);
      periph_d <= '0;
      xfer(ADDR_DIR_D, 32'h0, 1'b0);
      chk("dir_d", q, 32'h0000);
      chk("data_d", {16'h0, pad_d.data}, 32'h0001);
      xfer(ADDR_LAT_D, 32'h0, 1'b0);
      chk("lat_d", q, 32'h0001);
      $display("ports c d done");
      xfer(16'h0B1C, 32'hFFFF, 1'b1);
      chk("err", {31'h0, err}, 32'h1);
      xfer(16'h0B1C, 32'h0, 1'b0);
      chk("rd", q, 32'h0);
      idle;
      $display("unmapped done");
      end_sim;
   end
endmodule : spiop_top_test
